/* File: spisf_pkg.sv */
/*
 * Package of the serial port status and error flag block: register offsets,
 * bit positions, reset values, link timing and the carrier types.
 * Assumes an 8-bit register port and a 250 MHz block clock.
 */
package spisf_pkg;

	// Register offsets on the plain register port.
	localparam logic [2:0] SPISF_OFF_CSR   = 3'h0;
	localparam logic [2:0] SPISF_OFF_DATA  = 3'h1;
	localparam logic [2:0] SPISF_OFF_CTRL  = 3'h2;
	localparam logic [2:0] SPISF_OFF_ISTAT = 3'h3;
	localparam logic [2:0] SPISF_OFF_IMASK = 3'h4;

	// Control/status register bit positions.
	localparam int SPISF_CSR_TC   = 7;
	localparam int SPISF_CSR_WRITE_COLLISION_FLAG = 6;
	localparam int SPISF_CSR_OVR  = 5;
	localparam int SPISF_CSR_MASTER_FAULT_FLAG = 4;
	localparam int SPISF_CSR_SOD  = 2;
	localparam int SPISF_CSR_SSM  = 1;
	localparam int SPISF_CSR_SSI  = 0;

	// Control register bit positions.
	localparam int SPISF_CTRL_IRQE = 7;
	localparam int SPISF_CTRL_EN   = 6;
	localparam int SPISF_CTRL_MSTR = 4;
	localparam int SPISF_CTRL_CPOL = 3;
	localparam int SPISF_CTRL_CLOCK_PHASE_SELECT = 2;

	// Interrupt status and mask bit positions.
	localparam int SPISF_IRQ_TC   = 0;
	localparam int SPISF_IRQ_WRITE_COLLISION_FLAG = 1;
	localparam int SPISF_IRQ_OVR  = 2;
	localparam int SPISF_IRQ_MASTER_FAULT_FLAG = 3;

	// Reset values.
	localparam logic [7:0] SPISF_CSR_RST   = 8'h00;
	localparam logic [7:0] SPISF_CTRL_RST  = 8'h00;
	localparam logic [7:0] SPISF_DATA_RST  = 8'h00;
	localparam logic [3:0] SPISF_ISTAT_RST = 4'h0;
	localparam logic [3:0] SPISF_IMASK_RST = 4'hF;

	// Master clock timing: half period of the generated serial clock.
	localparam int         SPISF_CLK_NS       = 4;
	localparam int         SPISF_SCK_HALF_NS  = 24;
	localparam logic [3:0] SPISF_SCK_HALF_CYC = 4'(SPISF_SCK_HALF_NS / SPISF_CLK_NS);
	localparam logic [3:0] SPISF_BITS         = 4'h8;

	typedef enum logic {
		SPISF_LS_IDLE = 1'b0,
		SPISF_LS_RUN  = 1'b1
	} spisf_lstate_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} spisf_bus_req_t;

	typedef struct packed {
		logic sck;
		logic ss_n;
		logic miso;
		logic mosi;
	} spisf_pin_in_t;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} spisf_pin_out_t;

endpackage : spisf_pkg

/* File: spisf_link.sv */
/*
 * Minimal byte shifter facing the serial pins, master or slave.
 * Assumes pin inputs are asynchronous; all are synchronised here.
 */
`timescale 1ns/1ps
module spisf_link (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     ce,
	input  wire spisf_pkg::spisf_pin_in_t pins_in,
	input  wire logic                     serial_port_enable,
	input  wire logic                     mstr,
	input  wire logic                     cpol,
	input  wire logic                     clock_phase_select,
	input  wire logic                     ss_int,
	input  wire logic                     tx_load,
	input  wire logic [7:0]               tx_byte,
	output logic                          ss_pin_lvl,
	output logic                          busy,
	output logic                          done,
	output logic [7:0]                    rx_byte,
	output logic                          sck_o,
	output logic                          data_o
);
	import spisf_pkg::*;

	spisf_pin_in_t sync1_ff, sync2_ff;
	logic          sck_d_ff;
	spisf_lstate_t state_ff, nxt_state;
	logic [3:0]    hcnt_ff, nxt_hcnt, bcnt_ff, nxt_bcnt, cnt_after;
	logic [7:0]    tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh, rx_ff, nxt_rx;
	logic          sck_ff, nxt_sck, data_ff, nxt_data, first_ff, nxt_first;
	logic          done_ff, nxt_done;
	logic          slv_on, half_tick, lead, trail, sample, shift, sin;

	always_comb begin
		slv_on    = serial_port_enable & ~mstr & ~ss_int;
		half_tick = (state_ff == SPISF_LS_RUN) && (hcnt_ff == SPISF_SCK_HALF_CYC - 4'h1);
		if (mstr) begin
			lead  = half_tick & (sck_ff == cpol);
			trail = half_tick & (sck_ff != cpol);
		end else begin
			lead  = slv_on & (sync2_ff.sck != sck_d_ff) & (sync2_ff.sck != cpol);
			trail = slv_on & (sync2_ff.sck != sck_d_ff) & (sync2_ff.sck == cpol);
		end
		sample    = clock_phase_select ? trail : lead;
		shift     = clock_phase_select ? lead : trail;
		sin       = mstr ? sync2_ff.miso : sync2_ff.mosi;
		cnt_after = sample ? bcnt_ff + 4'h1 : bcnt_ff;
		nxt_state = state_ff;
		nxt_hcnt  = hcnt_ff;
		nxt_bcnt  = cnt_after;
		nxt_tx_sh = tx_sh_ff;
		nxt_rx_sh = sample ? {rx_sh_ff[6:0], sin} : rx_sh_ff;
		nxt_rx    = rx_ff;
		nxt_sck   = sck_ff;
		nxt_data  = data_ff;
		nxt_first = first_ff;
		nxt_done  = 1'b0;
		if (state_ff == SPISF_LS_RUN) begin
			nxt_hcnt = half_tick ? 4'h0 : hcnt_ff + 4'h1;
			if (half_tick)
				nxt_sck = ~sck_ff;
		end else begin
			nxt_sck = cpol;
		end
		if (shift) begin
			nxt_data  = first_ff ? tx_sh_ff[7] : tx_sh_ff[6];
			nxt_first = 1'b0;
			if (!first_ff)
				nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
		end
		// A master ends on its last trailing edge so the clock rests idle.
		if ((mstr ? trail : sample) && cnt_after == SPISF_BITS) begin
			nxt_done  = 1'b1;
			nxt_rx    = nxt_rx_sh;
			nxt_bcnt  = 4'h0;
			nxt_state = SPISF_LS_IDLE;
		end
		// A slave deselected between bytes restarts its bit count.
		if (!mstr && !slv_on) begin
			nxt_bcnt  = 4'h0;
			nxt_first = clock_phase_select;
		end
		if (tx_load) begin
			nxt_tx_sh = tx_byte;
			nxt_data  = tx_byte[7];
			nxt_first = clock_phase_select;
			if (mstr && serial_port_enable) begin
				nxt_state = SPISF_LS_RUN;
				nxt_hcnt  = 4'h0;
				nxt_bcnt  = 4'h0;
				nxt_sck   = cpol;
			end
		end
		if (!serial_port_enable)
			nxt_state = SPISF_LS_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_ff <= '1;
			sync2_ff <= '1;
			sck_d_ff <= 1'b0;
			state_ff <= SPISF_LS_IDLE;
			hcnt_ff  <= 4'h0;
			bcnt_ff  <= 4'h0;
			tx_sh_ff <= 8'h00;
			rx_sh_ff <= 8'h00;
			rx_ff    <= 8'h00;
			sck_ff   <= 1'b0;
			data_ff  <= 1'b0;
			first_ff <= 1'b0;
			done_ff  <= 1'b0;
		end else if (ce) begin
			sync1_ff <= pins_in;
			sync2_ff <= sync1_ff;
			sck_d_ff <= sync2_ff.sck;
			state_ff <= nxt_state;
			hcnt_ff  <= nxt_hcnt;
			bcnt_ff  <= nxt_bcnt;
			tx_sh_ff <= nxt_tx_sh;
			rx_sh_ff <= nxt_rx_sh;
			rx_ff    <= nxt_rx;
			sck_ff   <= nxt_sck;
			data_ff  <= nxt_data;
			first_ff <= nxt_first;
			done_ff  <= nxt_done;
		end
	end

	assign ss_pin_lvl = sync2_ff.ss_n;
	assign busy       = mstr ? (state_ff == SPISF_LS_RUN) : (slv_on & (~clock_phase_select | (bcnt_ff != 4'h0)));
	assign done       = done_ff;
	assign rx_byte    = rx_ff;
	assign sck_o      = sck_ff;
	assign data_o     = data_ff;

endmodule : spisf_link

/* File: spisf_flags.sv */
/*
 * Status and error flag logic of a serial peripheral port, with its
 * control/status, data, control, interrupt status and mask registers.
 * Assumes a single-cycle register port on clk and asynchronous serial pins.
 */
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module spisf_flags (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      ce,
	input  wire spisf_pkg::spisf_bus_req_t bus_req,
	output logic [7:0]                     rdata,
	input  wire spisf_pkg::spisf_pin_in_t  pins_in,
	output spisf_pkg::spisf_pin_out_t      pins_out,
	output logic                           irq
);
	import spisf_pkg::*;

	// Control/status register state.
	logic       tc_ff, nxt_tc;
	logic       write_collision_flag_ff, nxt_write_collision_flag;
	logic       ovr_ff, nxt_ovr;
	logic       master_fault_flag_ff, nxt_master_fault_flag;
	logic       sod_ff, nxt_sod;
	logic       ssm_ff, nxt_ssm;
	logic       ssi_ff, nxt_ssi;

	// Control register state.
	logic       irqe_ff, nxt_irqe;
	logic       spe_ff, nxt_spe;
	logic       mstr_ff, nxt_mstr;
	logic       cpol_ff, nxt_cpol;
	logic       clock_phase_select_ff, nxt_clock_phase_select;

	// Clearing sequence trackers.
	logic       csr_seen_ff, nxt_csr_seen;
	logic       csr_rd_ff, nxt_csr_rd;
	logic       master_fault_flag_arm_ff, nxt_master_fault_flag_arm;

	// Data and interrupt registers.
	logic [7:0] rx_buf_ff, nxt_rx_buf;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [3:0] ist_ff, nxt_ist;
	logic [3:0] imask_ff, nxt_imask;

	// Decoded accesses and events.
	logic       csr_rd, csr_acc, data_rd, data_wr, data_acc, ctrl_wr;
	logic       wr_open, tx_load, write_collision_flag_set, ovr_set, tc_set, master_fault_flag_set;
	logic       ss_int, ss_pin_lvl, busy, done;
	logic [7:0] rx_byte;
	logic       sck_o, data_o;
	logic [3:0] events;

	always_comb begin
		csr_rd   = bus_req.rd && bus_req.addr == SPISF_OFF_CSR;
		csr_acc  = (bus_req.rd || bus_req.wr) && bus_req.addr == SPISF_OFF_CSR;
		data_rd  = bus_req.rd && bus_req.addr == SPISF_OFF_DATA;
		data_wr  = bus_req.wr && bus_req.addr == SPISF_OFF_DATA;
		data_acc = data_rd || data_wr;
		ctrl_wr  = bus_req.wr && bus_req.addr == SPISF_OFF_CTRL;
		ss_int   = ssm_ff ? ssi_ff : ss_pin_lvl;
		wr_open  = ~tc_ff | csr_rd_ff;
		write_collision_flag_set = data_wr & wr_open & busy;
		tx_load  = data_wr & wr_open & ~busy;
		tc_set   = done;
		ovr_set  = done & tc_ff;
		master_fault_flag_set = spe_ff & mstr_ff & ~ss_int;
		events   = '0;
		events[SPISF_IRQ_TC]   = tc_set;
		events[SPISF_IRQ_WRITE_COLLISION_FLAG] = write_collision_flag_set;
		events[SPISF_IRQ_OVR]  = ovr_set;
		events[SPISF_IRQ_MASTER_FAULT_FLAG] = master_fault_flag_set & ~master_fault_flag_ff;
	end

	// Flag and sequence next values; a setting event always wins over a clear.
	always_comb begin
		nxt_tc       = tc_ff;
		nxt_write_collision_flag     = write_collision_flag_ff;
		nxt_ovr      = ovr_ff;
		nxt_master_fault_flag     = master_fault_flag_ff;
		nxt_csr_seen = csr_seen_ff;
		nxt_csr_rd   = csr_rd_ff;
		nxt_master_fault_flag_arm = master_fault_flag_arm_ff;
		nxt_rx_buf   = rx_buf_ff;
		if (csr_acc && (tc_ff || write_collision_flag_ff))
			nxt_csr_seen = 1'b1;
		else if (data_acc)
			nxt_csr_seen = 1'b0;
		if (csr_rd)
			nxt_csr_rd = 1'b1;
		if (data_acc && csr_seen_ff) begin
			nxt_tc     = 1'b0;
			nxt_write_collision_flag   = 1'b0;
			nxt_csr_rd = 1'b0;
		end
		if (csr_rd)
			nxt_ovr = 1'b0;
		if (csr_acc && master_fault_flag_ff)
			nxt_master_fault_flag_arm = 1'b1;
		if (ctrl_wr && master_fault_flag_arm_ff) begin
			nxt_master_fault_flag     = 1'b0;
			nxt_master_fault_flag_arm = 1'b0;
		end
		// An overrun keeps the unread byte; the new one is lost.
		if (done && !tc_ff)
			nxt_rx_buf = rx_byte;
		if (tc_set) begin
			nxt_tc     = 1'b1;
			nxt_csr_rd = 1'b0;
		end
		if (write_collision_flag_set)
			nxt_write_collision_flag = 1'b1;
		if (ovr_set)
			nxt_ovr = 1'b1;
		if (master_fault_flag_set)
			nxt_master_fault_flag = 1'b1;
	end

	// Software control bits; reserved bit 3 is never stored and reads zero.
	always_comb begin
		nxt_sod  = sod_ff;
		nxt_ssm  = ssm_ff;
		nxt_ssi  = ssi_ff;
		nxt_irqe = irqe_ff;
		nxt_spe  = spe_ff;
		nxt_mstr = mstr_ff;
		nxt_cpol = cpol_ff;
		nxt_clock_phase_select = clock_phase_select_ff;
		nxt_imask = imask_ff;
		if (bus_req.wr && bus_req.addr == SPISF_OFF_CSR) begin
			nxt_sod = bus_req.wdata[SPISF_CSR_SOD];
			nxt_ssm = bus_req.wdata[SPISF_CSR_SSM];
			nxt_ssi = bus_req.wdata[SPISF_CSR_SSI];
		end
		if (ctrl_wr) begin
			nxt_irqe = bus_req.wdata[SPISF_CTRL_IRQE];
			nxt_spe  = bus_req.wdata[SPISF_CTRL_EN];
			nxt_mstr = bus_req.wdata[SPISF_CTRL_MSTR];
			nxt_cpol = bus_req.wdata[SPISF_CTRL_CPOL];
			nxt_clock_phase_select = bus_req.wdata[SPISF_CTRL_CLOCK_PHASE_SELECT];
		end
		if (bus_req.wr && bus_req.addr == SPISF_OFF_IMASK)
			nxt_imask = bus_req.wdata[3:0];
	end

	// Sticky interrupt status: write one to clear, a new event wins.
	always_comb begin
		nxt_ist = ist_ff;
		if (bus_req.wr && bus_req.addr == SPISF_OFF_ISTAT)
			nxt_ist = ist_ff & ~bus_req.wdata[3:0];
		nxt_ist = nxt_ist | events;
	end

	// Read data stand in the cycle after the read strobe only.
	always_comb begin
		nxt_rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				SPISF_OFF_CSR: begin
					nxt_rdata = {tc_ff, write_collision_flag_ff, ovr_ff, master_fault_flag_ff, 1'b0, sod_ff, ssm_ff, ssi_ff};
				end
				SPISF_OFF_DATA: begin
					nxt_rdata = rx_buf_ff;
				end
				SPISF_OFF_CTRL: begin
					nxt_rdata = {irqe_ff, spe_ff, 1'b0, mstr_ff, cpol_ff, clock_phase_select_ff, 2'b00};
				end
				SPISF_OFF_ISTAT: begin
					nxt_rdata = {4'h0, ist_ff};
				end
				SPISF_OFF_IMASK: begin
					nxt_rdata = {4'h0, imask_ff};
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			tc_ff       <= SPISF_CSR_RST[SPISF_CSR_TC];
			write_collision_flag_ff     <= SPISF_CSR_RST[SPISF_CSR_WRITE_COLLISION_FLAG];
			ovr_ff      <= SPISF_CSR_RST[SPISF_CSR_OVR];
			master_fault_flag_ff     <= SPISF_CSR_RST[SPISF_CSR_MASTER_FAULT_FLAG];
			sod_ff      <= SPISF_CSR_RST[SPISF_CSR_SOD];
			ssm_ff      <= SPISF_CSR_RST[SPISF_CSR_SSM];
			ssi_ff      <= SPISF_CSR_RST[SPISF_CSR_SSI];
			irqe_ff     <= SPISF_CTRL_RST[SPISF_CTRL_IRQE];
			spe_ff      <= SPISF_CTRL_RST[SPISF_CTRL_EN];
			mstr_ff     <= SPISF_CTRL_RST[SPISF_CTRL_MSTR];
			cpol_ff     <= SPISF_CTRL_RST[SPISF_CTRL_CPOL];
			clock_phase_select_ff     <= SPISF_CTRL_RST[SPISF_CTRL_CLOCK_PHASE_SELECT];
			csr_seen_ff <= 1'b0;
			csr_rd_ff   <= 1'b0;
			master_fault_flag_arm_ff <= 1'b0;
			rx_buf_ff   <= SPISF_DATA_RST;
			rdata_ff    <= 8'h00;
			ist_ff      <= SPISF_ISTAT_RST;
			imask_ff    <= SPISF_IMASK_RST;
		end else if (ce) begin
			tc_ff       <= nxt_tc;
			write_collision_flag_ff     <= nxt_write_collision_flag;
			ovr_ff      <= nxt_ovr;
			master_fault_flag_ff     <= nxt_master_fault_flag;
			sod_ff      <= nxt_sod;
			ssm_ff      <= nxt_ssm;
			ssi_ff      <= nxt_ssi;
			irqe_ff     <= nxt_irqe;
			spe_ff      <= nxt_spe;
			mstr_ff     <= nxt_mstr;
			cpol_ff     <= nxt_cpol;
			clock_phase_select_ff     <= nxt_clock_phase_select;
			csr_seen_ff <= nxt_csr_seen;
			csr_rd_ff   <= nxt_csr_rd;
			master_fault_flag_arm_ff <= nxt_master_fault_flag_arm;
			rx_buf_ff   <= nxt_rx_buf;
			rdata_ff    <= nxt_rdata;
			ist_ff      <= nxt_ist;
			imask_ff    <= nxt_imask;
		end
	end

	spisf_link u_link (
		.clk        (clk),
		.nrst       (nrst),
		.ce         (ce),
		.pins_in    (pins_in),
		.serial_port_enable        (spe_ff),
		.mstr       (mstr_ff),
		.cpol       (cpol_ff),
		.clock_phase_select       (clock_phase_select_ff),
		.ss_int     (ss_int),
		.tx_load    (tx_load),
		.tx_byte    (bus_req.wdata),
		.ss_pin_lvl (ss_pin_lvl),
		.busy       (busy),
		.done       (done),
		.rx_byte    (rx_byte),
		.sck_o      (sck_o),
		.data_o     (data_o)
	);

	// The data output is driven only when enabled and not disabled by software.
	always_comb begin
		pins_out.sck_o   = sck_o;
		pins_out.sck_oe  = spe_ff & mstr_ff;
		pins_out.mosi_o  = data_o;
		pins_out.mosi_oe = spe_ff & mstr_ff & ~sod_ff;
		pins_out.miso_o  = data_o;
		pins_out.miso_oe = spe_ff & ~mstr_ff & ~ss_int & ~sod_ff;
	end

	assign rdata = rdata_ff;
	assign irq   = irqe_ff & |(ist_ff & imask_ff);

endmodule : spisf_flags

/* File: spisf_flags_properties.sv */
/*
 * Checker of the serial port flag block, bound to its top module.
 * Assumes it sees only the top module's ports and that ce is high in reset.
 */
`timescale 1ns/1ps
module spisf_flags_checker (
	input wire logic                      clk,
	input wire logic                      nrst,
	input wire logic                      ce,
	input wire spisf_pkg::spisf_bus_req_t bus_req,
	input wire logic [7:0]                rdata,
	input wire spisf_pkg::spisf_pin_in_t  pins_in,
	input wire spisf_pkg::spisf_pin_out_t pins_out,
	input wire logic                      irq
);
	import spisf_pkg::*;
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [2:0] csr_ff;
	logic [2:0] nxt_csr;
	logic [3:0] imask_ff;
	logic [3:0] nxt_imask;
	logic       fault_now;

	// Shadow copies of the writable controls, taken from the register port.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_csr = csr_ff;
		nxt_imask = imask_ff;
		if (!nrst) begin
			nxt_ctrl = SPISF_CTRL_RST;
			nxt_csr = SPISF_CSR_RST[2:0];
			nxt_imask = SPISF_IMASK_RST;
		end else if (bus_req.wr && bus_req.addr == SPISF_OFF_CTRL) begin
			nxt_ctrl = bus_req.wdata & 8'hDC;
		end else if (bus_req.wr && bus_req.addr == SPISF_OFF_CSR) begin
			nxt_csr = bus_req.wdata[2:0];
		end else if (bus_req.wr && bus_req.addr == SPISF_OFF_IMASK) begin
			nxt_imask = bus_req.wdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (ce) begin
			ctrl_ff <= nxt_ctrl;
			csr_ff <= nxt_csr;
			imask_ff <= nxt_imask;
		end
	end

	assign fault_now = ctrl_ff[SPISF_CTRL_EN] & ctrl_ff[SPISF_CTRL_MSTR] &
		csr_ff[SPISF_CSR_SSM] & ~csr_ff[SPISF_CSR_SSI];

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_csr_read;
		ce && bus_req.rd && bus_req.addr == SPISF_OFF_CSR;
	endsequence

	sequence s_fault_held;
		fault_now [*2];
	endsequence

	a_rdata_quiet: assert property ($past(ce) && !$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	a_reset_quiet: assert property (disable iff (1'b0) ce && !nrst |=> !irq &&
		!pins_out.mosi_oe && !pins_out.miso_oe && !pins_out.sck_oe)
		else $error("outputs active after reset");
	a_output_off: assert property (csr_ff[SPISF_CSR_SOD] |->
		!pins_out.mosi_oe && !pins_out.miso_oe)
		else $error("data output driven while disabled");
	a_irq_gate: assert property (irq |-> ctrl_ff[SPISF_CTRL_IRQE] && imask_ff != 4'h0)
		else $error("interrupt without enable or mask");
	a_fault_sets: assert property (s_fault_held ##0 s_csr_read |=> rdata[SPISF_CSR_MASTER_FAULT_FLAG])
		else $error("mode fault flag not set");
	a_reserved_zero: assert property (s_csr_read |=> !rdata[3])
		else $error("reserved status bit reads one");
	a_csr_controls: assert property (s_csr_read |=> rdata[2:0] == csr_ff)
		else $error("status control bits do not read back");
	a_ctrl_readback: assert property (ce && bus_req.rd && bus_req.addr == SPISF_OFF_CTRL
		|=> rdata == ctrl_ff)
		else $error("control register does not read back");
	a_imask_readback: assert property (ce && bus_req.rd && bus_req.addr == SPISF_OFF_IMASK
		|=> rdata == {4'h0, imask_ff})
		else $error("mask register does not read back");
endmodule : spisf_flags_checker

bind spisf_flags spisf_flags_checker u_checker (.clk(clk), .nrst(nrst), .ce(ce),
	.bus_req(bus_req), .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));

/* File: spisf_partner.sv */
/*
 * Far side of the serial port: a slave answering a byte, and a master task.
 * Assumes clock phase zero, clock idle low and a 48 ns serial clock period.
 */
`timescale 1ns/1ps
module spisf_partner (
	input  wire logic       sck_in,
	input  wire logic       sck_act,
	input  wire logic       mosi_in,
	input  wire logic [7:0] reply,
	output logic            sck,
	output logic            ss_n,
	output logic            mosi,
	output logic            miso,
	output logic [7:0]      got,
	output int              edges
);
	localparam int HALF_NS = 24;
	int n;

	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
		miso = 1'b0;
		got = 8'h00;
		edges = 0;
		n = 0;
	end

	always @(posedge sck_in) begin
		got = {got[6:0], mosi_in};
		edges = edges + 1;
	end

	always @(posedge sck_act) begin
		n = 0;
		miso = reply[7];
	end

	always @(negedge sck_in) begin
		if (sck_act && n < 7) begin
			n = n + 1;
			miso = reply[3'(7 - n)];
		end
	end

	// A released line must not keep showing its last bit.
	always @(negedge sck_act) miso = ~miso;

	task automatic send(input logic [7:0] b);
		ss_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = b[i];
			#HALF_NS sck = 1'b1;
			#HALF_NS sck = 1'b0;
		end
		ss_n = 1'b1;
		mosi = ~mosi;
		#(2 * HALF_NS);
	endtask : send
endmodule : spisf_partner

/* File: spisf_flags_bench.sv */
/*
 * Self-checking bench of the serial port flag block with its partner.
 * Assumes the block clock at 250 MHz and the clock enable held high.
 */
`timescale 1ns/1ps
module spisf_flags_bench;
	import spisf_pkg::*;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} spisf_row_t;
	logic           clk;
	logic           nrst;
	spisf_bus_req_t req;
	logic [7:0]     rdata;
	spisf_pin_in_t  pin_i;
	spisf_pin_out_t pin_o;
	logic           irq;
	logic           p_sck;
	logic           p_ss_n;
	logic           p_mosi;
	logic           p_miso;
	logic [7:0]     p_got;
	int             p_edges;
	int             mark;
	int             fails;
	int             compares;
	logic [7:0]     seen;
	logic [7:0]     rst_exp [5];
	spisf_row_t     rows [6];

	assign pin_i.sck = p_sck;
	assign pin_i.ss_n = p_ss_n;
	assign pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi_o : p_mosi;
	assign pin_i.miso = pin_o.miso_oe ? pin_o.miso_o : p_miso;

	spisf_flags dut (.clk(clk), .nrst(nrst), .ce(1'b1), .bus_req(req), .rdata(rdata),
		.pins_in(pin_i), .pins_out(pin_o), .irq(irq));

	spisf_partner partner (.sck_in(pin_o.sck_o), .sck_act(pin_o.sck_oe), .mosi_in(pin_i.mosi),
		.reply(8'h3C), .sck(p_sck), .ss_n(p_ss_n), .mosi(p_mosi), .miso(p_miso),
		.got(p_got), .edges(p_edges));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [2:0] a);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		seen = rdata;
	endtask : bus_rd

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	initial begin
		#100000;
		fails++;
		final_report();
	end

	initial begin
		nrst = 1'b0;
		req = '0;
		rst_exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F};
		rows = '{'{SPISF_OFF_CSR, 8'hF7, 8'h07}, '{SPISF_OFF_CTRL, 8'hFF, 8'hDC},
			'{SPISF_OFF_IMASK, 8'hF5, 8'h05}, '{3'h5, 8'hFF, 8'h00},
			'{SPISF_OFF_IMASK, 8'h0F, 8'h0F}, '{SPISF_OFF_CSR, 8'h03, 8'h03}};
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a < 5; a++) begin
			bus_rd(3'(a));
			chk("reset value", seen, rst_exp[a]);
		end
		foreach (rows[i]) begin
			bus_wr(rows[i].addr, rows[i].wdata);
			bus_rd(rows[i].addr);
			chk("register row", seen, rows[i].exp);
		end
		// Master transfer with a collision, a blocked write and the interrupt.
		// Disabling first lets the partner restart its reply with the new frame.
		bus_wr(SPISF_OFF_CTRL, 8'h00);
		// Only completion may interrupt, so the wait below ends with the byte.
		bus_wr(SPISF_OFF_IMASK, 8'h01);
		bus_wr(SPISF_OFF_CTRL, 8'hD0);
		bus_wr(SPISF_OFF_DATA, 8'hA5);
		repeat (10) @(posedge clk);
		bus_wr(SPISF_OFF_DATA, 8'h5A);
		for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
		chk("irq on completion", {7'h0, irq}, 8'h01);
		chk("sent byte", p_got, 8'hA5);
		mark = p_edges;
		bus_wr(SPISF_OFF_DATA, 8'h11);
		repeat (40) @(posedge clk);
		chk("blocked write", 8'(p_edges - mark), 8'h00);
		bus_rd(SPISF_OFF_ISTAT);
		chk("event status", seen, 8'h03);
		bus_wr(SPISF_OFF_IMASK, 8'h00);
		#1 chk("irq masked", {7'h0, irq}, 8'h00);
		bus_wr(SPISF_OFF_IMASK, 8'h0F);
		#1 chk("irq unmasked", {7'h0, irq}, 8'h01);
		bus_rd(SPISF_OFF_CSR);
		chk("csr flags", seen, 8'hC3);
		bus_rd(SPISF_OFF_DATA);
		chk("received byte", seen, 8'h3C);
		bus_rd(SPISF_OFF_CSR);
		chk("csr cleared", seen, 8'h03);
		bus_wr(SPISF_OFF_ISTAT, 8'h0F);
		#1 chk("irq cleared", {7'h0, irq}, 8'h00);
		// Slave receives two bytes without the flag being cleared.
		bus_wr(SPISF_OFF_CSR, 8'h00);
		bus_wr(SPISF_OFF_CTRL, 8'hC0);
		partner.send(8'h81);
		partner.send(8'h42);
		repeat (8) @(posedge clk);
		bus_rd(SPISF_OFF_ISTAT);
		chk("overrun event", seen, 8'h05);
		bus_rd(SPISF_OFF_CSR);
		chk("overrun flag", seen, 8'hA0);
		bus_rd(SPISF_OFF_CSR);
		chk("overrun cleared", seen, 8'h80);
		bus_rd(SPISF_OFF_DATA);
		chk("kept byte", seen, 8'h81);
		bus_rd(SPISF_OFF_CSR);
		chk("transfer flag cleared", seen, 8'h00);
		// Soft select low while master raises the mode fault.
		bus_wr(SPISF_OFF_ISTAT, 8'h0F);
		bus_wr(SPISF_OFF_CTRL, 8'h50);
		bus_wr(SPISF_OFF_CSR, 8'h02);
		bus_rd(SPISF_OFF_CSR);
		chk("mode fault", seen, 8'h12);
		bus_wr(SPISF_OFF_CSR, 8'h03);
		bus_rd(SPISF_OFF_CSR);
		chk("fault held", seen, 8'h13);
		bus_wr(SPISF_OFF_CTRL, 8'h50);
		bus_rd(SPISF_OFF_CSR);
		chk("fault cleared", seen, 8'h03);
		bus_wr(SPISF_OFF_CSR, 8'h07);
		#1 chk("output disabled", {7'h0, pin_o.mosi_oe}, 8'h00);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		bus_rd(SPISF_OFF_CSR);
		chk("csr after reset", seen, 8'h00);
		final_report();
	end
endmodule : spisf_flags_bench
